// [dv/rsc_board.sv]
`timescale 1ns/1ps
// Reset line on the board: pull-up, an external open-drain driver and the device
module rsc_board
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] low_len,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  output logic reset_pin_i
);
  logic [7:0] cnt_q = 8'h00;
  // External driver holds the line low for whole clocks
  always @(posedge mclk)
  begin
    if (go)
      cnt_q <= low_len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  // Wired-AND with the pull-up, so a released line reads high
  assign reset_pin_i = !((cnt_q != 8'h00) || (reset_pin_oe && !reset_pin_o));
endmodule : rsc_board

// [dv/rsc_reset_ctrl_asserts.sv]
`timescale 1ns/1ps
// Port-level checks of the reset sequencer
module rsc_reset_ctrl_chk
  import rsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin_i,
  input wire logic reset_pin_oe,
  input wire logic debug_pin_i,
  input wire logic watchdog_timeout,
  input wire logic watchdog_reset_option,
  input wire logic supply_low,
  input wire logic core_rst,
  input wire logic chip_rst,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic ctl_reinit,
  input wire logic ipo_select,
  input wire logic watchdog_irq,
  input wire logic low_supply_irq,
  input wire logic port_load
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_vec;
    vector_fetch |-> vector_addr == RESET_VEC_HI;
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector address wrong");
  // Checks that a low pin holds reset one more clock; exit from ST_RESET sees the pin two clocks late and ST_WAKE exit ignores it
  property p_pin_hold;
    core_rst && !reset_pin_i |=> core_rst;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("left reset with pin low");
  property p_pin_run;
    !core_rst && !reset_pin_i ##1 !reset_pin_i [*5] |-> ##[0:3] core_rst;
  endproperty
  a_pin_run: assert property (p_pin_run) else $error("long pin low gave no reset");
  property p_wdt_rst;
    watchdog_timeout && watchdog_reset_option && !core_rst |-> ##[1:3] chip_rst;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog gave no reset");
  property p_wdt_irq;
    watchdog_timeout && !watchdog_reset_option && !core_rst && reset_pin_i |=> !chip_rst [*4];
  endproperty
  a_wdt_irq: assert property (p_wdt_irq) else $error("watchdog reset in irq mode");
  property p_low_irq;
    low_supply_irq |-> supply_low;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low-supply irq without low supply");
  property p_wake_hold;
    ctl_reinit |-> core_rst [*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake released core early");
  property p_ipo;
    port_load |-> ##[0:1] ipo_select;
  endproperty
  a_ipo: assert property (p_ipo) else $error("oscillator not selected after wake");
  property p_pin_free;
    vector_fetch |-> !reset_pin_oe;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("pin still driven at exit");
  property p_dbg;
    $fell(debug_pin_i) && core_rst && !chip_rst |-> ##[1:6] chip_rst;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug pin gave no reset");
  c_exit: cover property (vector_fetch);
  c_wake: cover property (ctl_reinit);
  c_wirq: cover property (watchdog_irq);
  c_lirq: cover property (low_supply_irq);
endmodule : rsc_reset_ctrl_chk

bind rsc_reset_ctrl rsc_reset_ctrl_chk u_chk (.*);

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import rsc_pkg::*;
  localparam int PC = 4;
  localparam int XC = 8;
  logic mclk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, supply_por_ok = 1'b1, brownout_detector = 1'b0;
  logic supply_low = 1'b0, ipo_tick = 1'b0, opt_xtal_en = 1'b0, watchdog_reset_option = 1'b1;
  logic brownout_in_sleep_option = 1'b1, watchdog_timeout = 1'b0, stop_req = 1'b0;
  logic debug_pin_i = 1'b1, go = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [7:0] wake_pins_i = 8'h0F, low_len = 8'h00, port_pin_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] vector_addr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_i;
  logic reset_pin_o, reset_pin_oe, core_rst, chip_rst, debugger_rst, vector_fetch, ctl_reinit;
  logic ipo_select, brownout_enable, watchdog_irq, low_supply_irq, port_load;
  int error_cnt = 0, n_tests = 0, seed = 32'h19a2b832, c, k, len, idx, n0, irq_cnt = 0;
  logic [7:0] pirq_q = 8'h00;
  rsc_reset_ctrl #(.PLAIN_CYC(PC), .XTAL_CYC(XC), .FILTER_CYC(2)) DUT (.*);
  rsc_board u_board (.mclk(mclk), .go(go), .low_len(low_len), .reset_pin_o(reset_pin_o),
    .reset_pin_oe(reset_pin_oe), .reset_pin_i(reset_pin_i));
  always #25 mclk = ~mclk;
  // Oscillator tick every second clock keeps delays short but countable
  always @(posedge mclk)
  begin
    ipo_tick <= ~ipo_tick;
    if (watchdog_irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
    // Keep the pin interrupt vector of the last wake exit
    if (port_load === 1'b1)
      pirq_q <= port_pin_irq;
  end
  function automatic logic [31:0] exp_cause(input logic [3:0] f);
    return {24'h0, f, 3'h0, supply_low};
  endfunction : exp_cause
  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask : chk
  task automatic tmo(input int i, input int lim);
    if (i >= lim)
    begin
      error_cnt++;
      finish_test();
    end
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Ready is sampled mid-cycle; it only changes on a rising edge, so it equals the edge value
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int i;
    i = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge mclk); while (!(s_axi_awready && s_axi_wready) && ++i < 20);
    @(posedge mclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge mclk); while (!s_axi_bvalid && ++i < 40);
    @(posedge mclk);
    s_axi_bready <= 1'b0;
    tmo(i, 40);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int i;
    i = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (!s_axi_arready && ++i < 20);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk); while (!s_axi_rvalid && ++i < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge mclk);
    s_axi_rready <= 1'b0;
    tmo(i, 40);
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rdc
  task automatic wait_vf();
    c = 0;
    do @(negedge mclk); while (vector_fetch !== 1'b1 && ++c < 20000);
    tmo(c, 20000);
  endtask : wait_vf
  task automatic stop_in();
    @(posedge mclk);
    stop_req <= 1'b1;
    @(posedge mclk);
    stop_req <= 1'b0;
    cyc(3);
  endtask : stop_in
  task automatic pulse_wdt();
    @(posedge mclk);
    watchdog_timeout <= 1'b1;
    @(posedge mclk);
    watchdog_timeout <= 1'b0;
  endtask : pulse_wdt
  task automatic pin_low(input int n);
    @(posedge mclk);
    go <= 1'b1;
    low_len <= n[7:0];
    @(posedge mclk);
    go <= 1'b0;
  endtask : pin_low
  // Main sequence: power-on, every reset source, then the power-down exits
  initial
  begin
    cyc(6);
    rst <= 1'b0;
    cyc(2);
    chk(reset_pin_oe, 1'b1);
    wait_vf();
    chk(c >= 2 * PC - 3 && c <= 2 * PC + 8, 1'b1);
    chk(vector_addr, RESET_VEC_HI);
    rdc(OFS_CAUSE, exp_cause(4'h8));
    rdc(OFS_CAUSE, exp_cause(4'h0));
    rd(4'h2);
    chk(r, RESP_SLVERR);
    opt_xtal_en <= 1'b1;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    wait_vf();
    chk(c >= 2 * XC && c <= 2 * XC + 10, 1'b1);
    opt_xtal_en <= 1'b0;
    supply_por_ok <= 1'b0;
    brownout_detector <= 1'b1;
    cyc(10);
    chk(core_rst, 1'b1);
    chk(debugger_rst, 1'b1);
    supply_por_ok <= 1'b1;
    brownout_detector <= 1'b0;
    wait_vf();
    rdc(OFS_CAUSE, exp_cause(4'h8));
    // Watchdog in interrupt mode, then in reset mode
    for (k = 0; k < 2; k++)
    begin
      watchdog_reset_option <= k[0];
      pulse_wdt();
      if (k == 1)
        wait_vf();
      else
        cyc(20);
      chk(core_rst, 1'b0);
      rdc(OFS_CAUSE, exp_cause(4'h2));
    end
    // Pin lows: too short, a random sure width, and held past the delay
    for (k = 0; k < 3; k++)
    begin
      len = (k == 0) ? 2 : (k == 1) ? 4 + $unsigned($random(seed)) % 4 : 40;
      pin_low(len);
      if (k == 0)
        cyc(20);
      else
        wait_vf();
      if (k == 2)
        chk(c >= len && c <= len + 6, 1'b1);
      rdc(OFS_CAUSE, exp_cause(k == 0 ? 4'h0 : 4'h1));
    end
    wr(OFS_CTRL, 32'h2);
    @(negedge mclk);
    chk(reset_pin_oe, 1'b1);
    wait_vf();
    rd(OFS_CAUSE);
    wr(OFS_CTRL, 32'h1);
    wait_vf();
    rdc(OFS_CAUSE, exp_cause(4'h8));
    rdc(OFS_CTRL, 32'h0);
    supply_low <= 1'b1;
    wr(OFS_CTRL, 32'h4);
    @(negedge mclk);
    chk(low_supply_irq, 1'b1);
    wr(OFS_CAUSE, 32'h0);
    rdc(OFS_CAUSE, exp_cause(4'h0));
    rdc(OFS_CAUSE, exp_cause(4'h0));
    wr(OFS_CTRL, 32'hC);
    @(negedge mclk);
    chk(low_supply_irq, 1'b0);
    chk(brownout_enable, 1'b0);
    supply_low <= 1'b0;
    // Wake pin rises on the first pass and falls on the second
    for (k = 0; k < 2; k++)
    begin
      idx = (k == 0 ? 4 : 0) + $unsigned($random(seed)) % 4;
      wr(OFS_WAKE_EN, 32'h1 << idx);
      stop_in();
      wake_pins_i[idx] <= ~wake_pins_i[idx];
      wait_vf();
      chk(c >= OSC_START_CYC + 2 * PC - 2, 1'b1);
      chk(ipo_select, 1'b1);
      rdc(OFS_CAUSE, exp_cause(4'h4));
      rdc(OFS_PORT_IN, {24'h0, wake_pins_i});
      chk(pirq_q, 32'h1 << idx);
    end
    wr(OFS_CTRL, 32'h10);
    for (k = 0; k < 2; k++)
    begin
      watchdog_reset_option <= k[0];
      stop_in();
      n0 = irq_cnt;
      pulse_wdt();
      wait_vf();
      cyc(5);
      chk(irq_cnt - n0, k == 0);
      rdc(OFS_CAUSE, exp_cause(4'h6));
    end
    brownout_in_sleep_option <= 1'b0;
    stop_in();
    chk(brownout_enable, 1'b0);
    pin_low(1);
    cyc(10);
    chk(chip_rst, 1'b0);
    debug_pin_i <= 1'b0;
    cyc(5);
    debug_pin_i <= 1'b1;
    wait_vf();
    rdc(OFS_CAUSE, exp_cause(4'h8));
    finish_test();
  end
endmodule : tb

// [verilog/rsc_pkg.sv]
package rsc_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] OFS_CAUSE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_WAKE_EN = 4'h8;
  localparam logic [3:0] OFS_PORT_IN = 4'hC;
  // Cause register bit positions
  localparam int CAUSE_POR_BIT = 7;
  localparam int CAUSE_WAKE_BIT = 6;
  localparam int CAUSE_WDT_BIT = 5;
  localparam int CAUSE_PIN_BIT = 4;
  localparam int CAUSE_LOW_BIT = 0;
  // Control register bit positions
  localparam int CTRL_DBG_RST_BIT = 0;
  localparam int CTRL_PIN_LOW_BIT = 1;
  localparam int CTRL_LOW_IE_BIT = 2;
  localparam int CTRL_BOD_DIS_BIT = 3;
  localparam int CTRL_IRQ_EN_BIT = 4;
  localparam int CTRL_W = 5;
  // Reset values
  localparam logic [3:0] CAUSE_RST = 4'h8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // Delay counts, in internal precision oscillator cycles
  localparam int DELAY_PLAIN_IPO = 66;
  localparam int DELAY_XTAL_IPO = 5000;
  localparam int DELAY_W = 13;
  // Oscillator start-up time and the clock it is counted on
  localparam int OSC_START_NS = 4000;
  localparam int MCLK_PERIOD_NS = 50;
  localparam int OSC_START_CYC = (OSC_START_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // Reset pin low width that always starts a reset in running mode, in system clocks
  localparam int PIN_LOW_MIN_CYC = 4;
  localparam int PIN_FILTER_CYC = 4;
  localparam int PIN_CNT_W = 8;
  // Reset vector location in program memory
  localparam logic [15:0] RESET_VEC_HI = 16'h0002;
  localparam logic [15:0] RESET_VEC_LO = 16'h0003;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer states, Gray along reset -> run -> stop -> osc -> wake; wake -> run changes all three bits
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RUN = 3'h1,
    ST_STOP = 3'h3,
    ST_OSC = 3'h2,
    ST_WAKE = 3'h6
  } rsc_state_t;
endpackage : rsc_pkg

// [verilog/rsc_reset_ctrl.sv]
`timescale 1ns/1ps
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int WAKE_W = 8,
  parameter int PLAIN_CYC = rsc_pkg::DELAY_PLAIN_IPO,
  parameter int XTAL_CYC = rsc_pkg::DELAY_XTAL_IPO,
  parameter int FILTER_CYC = rsc_pkg::PIN_FILTER_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog detectors, oscillator tick and option bits
  input wire logic supply_por_ok,
  input wire logic brownout_detector,
  input wire logic supply_low,
  input wire logic ipo_tick,
  input wire logic opt_xtal_en,
  input wire logic watchdog_reset_option,
  input wire logic brownout_in_sleep_option,
  // Events from core and watchdog
  input wire logic watchdog_timeout,
  input wire logic stop_req,
  // Pins
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic debug_pin_i,
  input wire logic [WAKE_W-1:0] wake_pins_i,
  // Results
  output logic core_rst,
  output logic chip_rst,
  output logic debugger_rst,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic ctl_reinit,
  output logic ipo_select,
  output logic brownout_enable,
  output logic watchdog_irq,
  output logic low_supply_irq,
  output logic port_load,
  output logic [WAKE_W-1:0] port_pin_irq
);
  import rsc_pkg::*;

  localparam logic [DELAY_W-1:0] PLAIN_T = DELAY_W'(PLAIN_CYC - 1);
  localparam logic [DELAY_W-1:0] XTAL_T = DELAY_W'(XTAL_CYC - 1);
  localparam logic [DELAY_W-1:0] OSC_T = DELAY_W'(OSC_START_CYC - 1);
  localparam logic [PIN_CNT_W-1:0] PIN_MIN = PIN_CNT_W'(PIN_LOW_MIN_CYC);
  localparam logic [PIN_CNT_W-1:0] PIN_FILT = PIN_CNT_W'(FILTER_CYC);

  typedef struct packed {
    rsc_state_t st;
    logic [DELAY_W-1:0] cnt;
    logic pin_s1;
    logic pin_s2;
    logic [PIN_CNT_W-1:0] low_cnt;
    logic internal_src;
    logic wdt_irq_pend;
    logic [3:0] cause;
    logic [CTRL_W-1:0] ctrl;
    logic [WAKE_W-1:0] wake_en;
    logic [WAKE_W-1:0] last_pins;
    logic [WAKE_W-1:0] port_in;
    logic [WAKE_W-1:0] pin_irq;
    logic port_load;
    logic fetch;
    logic [15:0] vec;
    logic reinit;
    logic ipo_sel;
    logic wdt_irq;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rsc_regs_t;

  rsc_regs_t q;
  rsc_regs_t d;

  logic bod_en;
  logic low_live;
  logic por_hold;
  logic pin_trig;
  logic wr_go;
  logic rd_go;
  logic [DELAY_W-1:0] delay_t;
  logic [WAKE_W-1:0] pin_change;

  // Brownout and low-supply share the detector; power-down keeps it only by option
  assign bod_en = !q.ctrl[CTRL_BOD_DIS_BIT]
                  && (q.st != ST_STOP || brownout_in_sleep_option);
  assign low_live = supply_low && bod_en;
  assign por_hold = !supply_por_ok || (brownout_detector && bod_en);
  assign delay_t = opt_xtal_en ? XTAL_T : PLAIN_T;
  assign pin_change = (wake_pins_i ^ q.last_pins) & q.wake_en;
  // Running mode needs four synced lows; power-down uses the FILTER_CYC count instead
  assign pin_trig = (q.st == ST_STOP) ? (q.low_cnt >= PIN_FILT)
                                      : (q.low_cnt >= PIN_MIN);

  // Write and read handshakes; one transfer of each kind at a time
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
  assign rd_go = s_axi_arvalid && !q.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // Next-state logic for the whole block
  always_comb
  begin
    d = q;
    d.fetch = 1'b0;
    d.reinit = 1'b0;
    d.wdt_irq = 1'b0;
    d.port_load = 1'b0;
    d.pin_irq = '0;
    // Two-flop synchroniser; only the second flop feeds the width counter
    d.pin_s1 = reset_pin_i;
    d.pin_s2 = q.pin_s1;
    // Count synced low width; our reset-state drive of the pin is not counted, the CTRL_PIN_LOW_BIT drive is
    if (q.pin_s2 || q.internal_src)
    begin
      d.low_cnt = '0;
    end
    else if (q.low_cnt != '1)
    begin
      d.low_cnt = q.low_cnt + PIN_CNT_W'(1);
    end

    // Register writes
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      case (s_axi_awaddr)
        OFS_CTRL:
          if (s_axi_wstrb[0])
            d.ctrl = s_axi_wdata[CTRL_W-1:0];
        OFS_WAKE_EN:
          if (s_axi_wstrb[0])
            d.wake_en = s_axi_wdata[WAKE_W-1:0];
        OFS_CAUSE, OFS_PORT_IN: d.bresp = RESP_OKAY; // Read-only, write ignored
        default: d.bresp = RESP_SLVERR;
      endcase
    end

    // Register reads; reading the cause register clears its upper flags
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = '0;
      case (s_axi_araddr)
        OFS_CAUSE:
        begin
          d.rdata[CAUSE_POR_BIT:CAUSE_PIN_BIT] = q.cause;
          d.rdata[CAUSE_LOW_BIT] = low_live;
          d.cause = 4'h0;
        end
        OFS_CTRL: d.rdata[CTRL_W-1:0] = q.ctrl;
        OFS_WAKE_EN: d.rdata[WAKE_W-1:0] = q.wake_en;
        OFS_PORT_IN: d.rdata[WAKE_W-1:0] = q.port_in;
        default: d.rresp = RESP_SLVERR;
      endcase
    end

    // Sequencer; cause updates below come after the read clear, so events win
    case (q.st)
      ST_RESET:
      begin
        if (por_hold)
        begin
          d.cnt = '0;
          d.internal_src = 1'b1;
          d.cause = 4'h8;
        end
        else if (q.cnt != delay_t)
        begin
          if (ipo_tick)
            d.cnt = q.cnt + DELAY_W'(1);
        end
        else
        begin
          // Delay over: release our drive, then wait for the pin to read high
          d.internal_src = 1'b0;
          if (q.pin_s2 && !q.internal_src)
          begin
            d.st = ST_RUN;
            d.fetch = 1'b1;
            d.vec = RESET_VEC_HI;
            d.ipo_sel = 1'b1;
          end
        end
      end
      ST_RUN:
      begin
        d.last_pins = wake_pins_i;
        if (q.wdt_irq_pend && q.ctrl[CTRL_IRQ_EN_BIT])
        begin
          d.wdt_irq = 1'b1;
        end
        d.wdt_irq_pend = 1'b0;
        if (por_hold)
        begin
          d.st = ST_RESET;
          d.cnt = '0;
          d.internal_src = 1'b1;
          d.cause = 4'h8;
          d.ctrl = CTRL_RST;
        end
        else if (q.ctrl[CTRL_DBG_RST_BIT])
        begin
          d.st = ST_RESET;
          d.cnt = '0;
          d.internal_src = 1'b1;
          d.cause = 4'h8;
          d.ctrl = CTRL_RST;
        end
        else if (pin_trig)
        begin
          d.st = ST_RESET;
          d.cnt = '0;
          d.internal_src = 1'b0;
          d.cause = 4'h1;
          d.ctrl = CTRL_RST;
        end
        else if (watchdog_timeout && watchdog_reset_option)
        begin
          d.st = ST_RESET;
          d.cnt = '0;
          d.internal_src = 1'b1;
          d.cause = {1'b0, 1'b0, 1'b1, q.cause[0]};
          d.ctrl = CTRL_RST;
        end
        else
        begin
          if (watchdog_timeout)
          begin
            d.wdt_irq = 1'b1;
            d.cause[1] = 1'b1;
          end
          if (stop_req)
          begin
            d.st = ST_STOP;
          end
        end
      end
      ST_STOP:
      begin
        d.ipo_sel = 1'b0;
        if (por_hold || !debug_pin_i || pin_trig)
        begin
          d.st = ST_RESET;
          d.cnt = '0;
          d.internal_src = !pin_trig;
          d.cause = pin_trig ? 4'h1 : 4'h8;
          d.ctrl = CTRL_RST;
        end
        else if (watchdog_timeout || (pin_change != '0))
        begin
          d.st = ST_OSC;
          d.cnt = '0;
          d.reinit = 1'b1;
          d.ipo_sel = 1'b1;
          d.wdt_irq_pend = watchdog_timeout && !watchdog_reset_option;
          d.cause = watchdog_timeout ? 4'h6 : 4'h4;
        end
      end
      ST_OSC:
      begin
        // Oscillator start-up is timed on the system clock
        if (q.cnt == OSC_T)
        begin
          d.st = ST_WAKE;
          d.cnt = '0;
        end
        else
          d.cnt = q.cnt + DELAY_W'(1);
      end
      ST_WAKE:
      begin
        if (q.cnt != delay_t)
        begin
          if (ipo_tick)
            d.cnt = q.cnt + DELAY_W'(1);
        end
        else
        begin
          // All levels reach the port at the end of the delay; only pins still changed then raise port_pin_irq
          d.st = ST_RUN;
          d.fetch = 1'b1;
          d.vec = RESET_VEC_HI;
          d.port_in = wake_pins_i;
          d.port_load = 1'b1;
          d.pin_irq = pin_change;
        end
      end
      default:
      begin
        d.st = ST_RESET;
        d.cnt = '0;
      end
    endcase
  end

  // State register; cause starts as power-on
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '{st: ST_RESET, cnt: '0, pin_s1: 1'b1, pin_s2: 1'b1, low_cnt: '0,
             internal_src: 1'b1, wdt_irq_pend: 1'b0, cause: CAUSE_RST, ctrl: CTRL_RST,
             wake_en: '0, last_pins: '0, port_in: '0, pin_irq: '0, port_load: 1'b0,
             fetch: 1'b0, vec: RESET_VEC_HI, reinit: 1'b0, ipo_sel: 1'b1, wdt_irq: 1'b0,
             bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rresp: RESP_OKAY, rdata: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs; pin is open drain, low only while we enable it
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = (q.st == ST_RESET && q.internal_src)
                        || q.ctrl[CTRL_PIN_LOW_BIT];
  assign core_rst = (q.st != ST_RUN);
  assign chip_rst = (q.st == ST_RESET);
  assign debugger_rst = (q.st == ST_RESET) && q.cause[3] && !supply_por_ok;
  assign vector_fetch = q.fetch;
  assign vector_addr = q.vec;
  assign ctl_reinit = q.reinit;
  assign ipo_select = q.ipo_sel;
  assign brownout_enable = bod_en;
  assign watchdog_irq = q.wdt_irq;
  assign low_supply_irq = low_live && q.ctrl[CTRL_LOW_IE_BIT];
  assign port_load = q.port_load;
  assign port_pin_irq = q.pin_irq;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
endmodule : rsc_reset_ctrl
